// ===== common/mfr_map.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef MFR_MAP_SVH
`define MFR_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define MFR_A_OPCTL 8'h00
`define MFR_A_CMD 8'h04
`define MFR_A_ADC 8'h08
`define MFR_A_FDTHR 8'h0C
`define MFR_A_IOCFG 8'h10
`define MFR_A_REGV 8'h14
`define MFR_A_REGD 8'h18
`define MFR_A_AUX 8'h1C
// ****************************************
// field positions
// ****************************************
`define MFR_B_EN 0
`define MFR_B_FDSEL 1
`define MFR_B_AMP 0
`define MFR_B_PHS 1
`define MFR_B_ADJ 2
`define MFR_B_SUP 0
`define MFR_B_REGS 4
`define MFR_F_PACT 0
`define MFR_F_PDEA 4
`define MFR_F_CACT 8
`define MFR_F_CDEA 12
// ****************************************
// reset values
// ****************************************
`define MFR_RST_FDTHR 16'h0000
`define MFR_RST_VCODE 4'h0
// ****************************************
// timing and voltage figures
// ****************************************
`define MFR_CLK_MHZ 250
`define MFR_CONV_NS 16500
`define MFR_CONV_CYC ((`MFR_CONV_NS * `MFR_CLK_MHZ) / 1000)
`define MFR_ADC_LSB_NV 7812500
`define MFR_V5_BASE_MV 13'h0E10
`define MFR_V5_STEP_MV 13'h0078
`define MFR_V3_BASE_MV 13'h0960
`define MFR_V3_STEP_MV 13'h0064
`define MFR_AD_FIXED_MV 13'h0D48
`endif

// ===== common/mfr_pkg.sv
// types shared by the measurement and supply control modules
package mfr_pkg;
  // converter input routing
  typedef enum logic [1:0] {
    SRC_IDLE = 2'h0,
    SRC_PHASE = 2'h1,
    SRC_AMP = 2'h2,
    SRC_SUP = 2'h3
  } mfr_src_t;
  // converter sequencer states
  typedef enum logic [1:0] {SAR_IDLE = 2'h1, SAR_RUN = 2'h2} mfr_sar_st_t;
  // command control states
  typedef enum logic [2:0] {CT_IDLE = 3'h1, CT_START = 3'h2, CT_WAIT = 3'h4} mfr_ct_st_t;
endpackage

// ===== common/mfr_cnv_if.sv
// request and answer bundle between command control and converter sequencer
`timescale 1ns/1ps
interface mfr_cnv_if;
  logic start;        // one-cycle start request
  logic busy;         // conversion running
  logic done;         // one-cycle end of conversion
  logic [7:0] result; // last converted code
  modport ctl (output start, input busy, input done, input result);
  modport sar (input start, output busy, output done, output result);
endinterface

// ===== rtl/mfr_sar.sv
// successive-approximation sequencer: eight trial steps, one result write
`timescale 1ns/1ps
`include "mfr_map.svh"
module mfr_sar #(
  parameter int CONV_CYC = `MFR_CONV_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmp_in,
  output logic [7:0] dac,
  mfr_cnv_if.sar cv
);
  // cycles per trial bit, never below one
  localparam int STEP = (CONV_CYC / 8 < 1) ? 1 : CONV_CYC / 8;
  logic s1, s2, s3, cmp; // comparator synchroniser and settled value
  mfr_pkg::mfr_sar_st_t st;
  logic [2:0] idx;       // bit under trial
  logic [15:0] cnt;      // settle time of one trial
  logic [7:0] kept;      // trial code after the decision
  logic [15:0] hc;       // helper: cycles spent converting
  // ****************************************
  // comparator input
  // ****************************************
  // the pin is async: three flops, accept once the last two agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      cmp <= 1'b0;
    end else begin
      s1 <= cmp_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        cmp <= s3;
      end
    end
  end
  // high comparator keeps the trial bit
  always_comb begin
    kept = cmp ? dac : (dac & ~(8'h01 << idx));
  end
  // ****************************************
  // trial sequence
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= mfr_pkg::SAR_IDLE;
      idx <= 3'h7;
      cnt <= 16'h0000;
      dac <= 8'h00;
      cv.busy <= 1'b0;
      cv.done <= 1'b0;
      cv.result <= 8'h00;
    end else begin
      cv.done <= 1'b0;
      case (st)
        mfr_pkg::SAR_IDLE: begin
          if (cv.start) begin
            st <= mfr_pkg::SAR_RUN;
            idx <= 3'h7;
            cnt <= 16'h0000;
            dac <= 8'h80; // msb trial first
            cv.busy <= 1'b1;
          end
        end
        mfr_pkg::SAR_RUN: begin
          if (cnt == 16'(STEP - 1)) begin
            cnt <= 16'h0000;
            if (idx == 3'h0) begin
              dac <= kept;
              cv.result <= kept; // one write, no partial code
              cv.done <= 1'b1;
              cv.busy <= 1'b0;
              st <= mfr_pkg::SAR_IDLE;
            end else begin
              dac <= kept | (8'h01 << (idx - 3'h1));
              idx <= idx - 3'h1;
            end
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        default: st <= mfr_pkg::SAR_IDLE;
      endcase
    end
  end
  // helper count for the timing check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hc <= 16'h0000;
    end else begin
      hc <= (st == mfr_pkg::SAR_IDLE) ? 16'h0000 : hc + 16'h0001;
    end
  end
  a_conv_time: assert property (@(posedge clk) disable iff (rst)
    cv.done |-> hc == 16'(8 * STEP))
    else $error("conversion length wrong");
  a_result_once: assert property (@(posedge clk) disable iff (rst)
    $changed(cv.result) |-> cv.done && $past(st) == mfr_pkg::SAR_RUN)
    else $error("result changed outside end of conversion");
endmodule

// ===== rtl/mfr_fdet.sv
// external field detector: threshold choice with hysteresis and events
`timescale 1ns/1ps
`include "mfr_map.svh"
module mfr_fdet (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmp_in,
  input wire logic [1:0] sel,
  input wire logic [15:0] thr,
  output logic [3:0] thr_code,
  output logic fd_on,
  output logic evt
);
  logic s1, s2, s3, cmp; // synchroniser and settled comparator
  logic next_on;
  // sel: 00 off, 01 collision avoidance, 1x peer detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      cmp <= 1'b0;
    end else begin
      s1 <= cmp_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        cmp <= s3;
      end
    end
  end
  assign next_on = (sel != 2'b00) && cmp;
  // off: compare to activation; on: to deactivation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fd_on <= 1'b0;
      evt <= 1'b0;
      thr_code <= 4'h0;
    end else begin
      fd_on <= next_on;
      evt <= sel[1] && (next_on != fd_on); // both edges
      if (sel[1]) begin
        thr_code <= fd_on ? thr[`MFR_F_PDEA +: 4] : thr[`MFR_F_PACT +: 4];
      end else begin
        thr_code <= fd_on ? thr[`MFR_F_CDEA +: 4] : thr[`MFR_F_CACT +: 4];
      end
    end
  end
  a_hyst_thr: assert property (@(posedge clk) disable iff (rst)
    fd_on |=> thr_code == ($past(sel[1]) ? $past(thr[7:4]) : $past(thr[15:12])))
    else $error("detected field not using deactivation level");
  a_fd_evt: assert property (@(posedge clk) disable iff (rst)
    $changed(fd_on) && $past(sel[1]) |-> evt)
    else $error("peer field change without event");
endmodule

// ===== rtl/mfr_ctrl.sv
// top: apb registers, converter command control, field detector, regulators
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "mfr_map.svh"
module mfr_ctrl #(
  parameter int CONV_CYC = `MFR_CONV_CYC // shorten for simulation
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_cmp,
  input wire logic field_cmp,
  output logic [7:0] adc_dac,
  output logic adc_ref_rel,
  output mfr_pkg::mfr_src_t adc_src,
  output logic [3:0] fd_thr_code,
  output logic fd_on,
  output logic fd_irq,
  output logic reg_on,
  output logic power_down,
  output logic [3:0] tx_rail_code,
  output logic [12:0] tx_rail_mv,
  output logic [12:0] ad_rail_mv
);
  // ****************************************
  // declarations
  // ****************************************
  mfr_cnv_if cv_bus (); // converter request bundle
  // software controlled state
  logic en_bit;                           // global enable
  logic [1:0] field_sense_enable_sel;     // detector selection
  logic [15:0] fd_thr;                    // four threshold levels
  logic low_supply_mode;                  // 3.3 V supply mode
  logic reg_manual;                       // manual regulator code select
  logic [3:0] reg_vcode;                  // manual voltage code
  logic [3:0] adj_code;                   // adjust command result
  // command control
  mfr_pkg::mfr_ct_st_t st;                // command state
  mfr_pkg::mfr_src_t next_src;            // source of a new command
  logic cmd_wr;                           // write to the command word
  logic any_cmd;                          // a command bit is set
  logic accept;                           // command taken
  // bus side
  logic wr_go;                            // write completes this edge
  logic rd_hit;                           // address is mapped
  logic [31:0] rd_word;                   // read mux output
  // regulator side
  logic [3:0] next_code;                  // regulated code to apply
  logic [12:0] next_mv;                   // decoded transmitter rail

  // ****************************************
  // apb slave
  // ****************************************
  // one wait state: pready rises in the second access cycle, which
  // lets read data come from a flop and keeps decode off the output
  assign wr_go = psel && penable && pready && pwrite;

  // read mux; unaligned or unknown addresses are unmapped
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      `MFR_A_OPCTL: begin
        rd_word[`MFR_B_EN] = en_bit;
        rd_word[`MFR_B_FDSEL +: 2] = field_sense_enable_sel;
      end
      `MFR_A_CMD: begin
        rd_word = 32'h0000_0000; // command bits are strobes
      end
      `MFR_A_ADC: begin
        rd_word[7:0] = cv_bus.result; // last result
      end
      `MFR_A_FDTHR: begin
        rd_word[15:0] = fd_thr;
      end
      `MFR_A_IOCFG: begin
        rd_word[`MFR_B_SUP] = low_supply_mode;
      end
      `MFR_A_REGV: begin
        rd_word[`MFR_B_REGS] = reg_manual;
        rd_word[3:0] = reg_vcode;
      end
      `MFR_A_REGD: begin
        rd_word[3:0] = tx_rail_code;
      end
      `MFR_A_AUX: begin
        rd_word[0] = fd_on;
        rd_word[1] = cv_bus.busy;
        rd_word[2] = reg_on;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // handshake and read data capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !rd_hit;
        // data sampled one edge before the answer edge
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // operation control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_bit <= 1'b0;
      field_sense_enable_sel <= 2'b00;
    end else if (wr_go && paddr == `MFR_A_OPCTL) begin
      en_bit <= pwdata[`MFR_B_EN];
      field_sense_enable_sel <= pwdata[`MFR_B_FDSEL +: 2];
    end
  end

  // threshold levels; host keeps activation >= deactivation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fd_thr <= `MFR_RST_FDTHR;
    end else if (wr_go && paddr == `MFR_A_FDTHR) begin
      fd_thr <= pwdata[15:0]; // no check on order
    end
  end

  // supply mode, 5 V after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_supply_mode <= 1'b0;
    end else if (wr_go && paddr == `MFR_A_IOCFG) begin
      low_supply_mode <= pwdata[`MFR_B_SUP];
    end
  end

  // regulator voltage control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_manual <= 1'b0; // automatic after reset
      reg_vcode <= `MFR_RST_VCODE;
    end else if (wr_go && paddr == `MFR_A_REGV) begin
      reg_manual <= pwdata[`MFR_B_REGS];
      reg_vcode <= pwdata[3:0];
    end
  end

  // ****************************************
  // command control
  // ****************************************
  // phase wins over amplitude, amplitude over adjust when several
  // bits are written at once; commands are dropped while powered down
  // or while a conversion is pending, the host polls the busy bit
  assign cmd_wr = wr_go && (paddr == `MFR_A_CMD);
  assign any_cmd = pwdata[`MFR_B_PHS] || pwdata[`MFR_B_AMP] || pwdata[`MFR_B_ADJ];
  assign accept = cmd_wr && any_cmd && en_bit && (st == mfr_pkg::CT_IDLE);

  always_comb begin
    if (pwdata[`MFR_B_PHS]) begin
      next_src = mfr_pkg::SRC_PHASE;
    end else if (pwdata[`MFR_B_AMP]) begin
      next_src = mfr_pkg::SRC_AMP;
    end else begin
      next_src = mfr_pkg::SRC_SUP;
    end
  end

  // command state: start pulse, then wait for the converter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= mfr_pkg::CT_IDLE;
    end else begin
      case (st)
        mfr_pkg::CT_IDLE: begin
          if (accept) begin
            st <= mfr_pkg::CT_START;
          end
        end
        mfr_pkg::CT_START: begin
          st <= mfr_pkg::CT_WAIT;
        end
        mfr_pkg::CT_WAIT: begin
          if (cv_bus.done) begin
            st <= mfr_pkg::CT_IDLE;
          end
        end
        default: st <= mfr_pkg::CT_IDLE;
      endcase
    end
  end

  // start strobe, high during the start state only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cv_bus.start <= 1'b0;
    end else begin
      cv_bus.start <= accept;
    end
  end

  // input routing and reference held for the whole command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_src <= mfr_pkg::SRC_IDLE;
      adc_ref_rel <= 1'b0;
    end else if (accept) begin
      adc_src <= next_src;
      // relative only for phase, absolute 0..2 V otherwise
      adc_ref_rel <= (next_src == mfr_pkg::SRC_PHASE);
    end else if (cv_bus.done) begin
      adc_src <= mfr_pkg::SRC_IDLE;
      adc_ref_rel <= 1'b0;
    end
  end

  // adjust command keeps the upper nibble of the supply reading;
  // phase codes are stored as converted, so they fall with phase
  // difference and clip outside the measurable span
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adj_code <= 4'h0;
    end else if (cv_bus.done && adc_src == mfr_pkg::SRC_SUP) begin
      adj_code <= cv_bus.result[7:4];
    end
  end

  // ****************************************
  // converter and field detector
  // ****************************************
  mfr_sar #(
    .CONV_CYC(CONV_CYC)
  ) u_sar (
    .clk(clk),
    .rst(rst),
    .cmp_in(adc_cmp),
    .dac(adc_dac),
    .cv(cv_bus)
  );

  mfr_fdet u_fdet (
    .clk(clk),
    .rst(rst),
    .cmp_in(field_cmp),
    .sel(field_sense_enable_sel),
    .thr(fd_thr),
    .thr_code(fd_thr_code),
    .fd_on(fd_on),
    .evt(fd_irq)
  );

  // ****************************************
  // regulators
  // ****************************************
  // code and voltage read zero while powered down
  always_comb begin
    if (!en_bit) begin
      next_code = 4'h0;
    end else if (reg_manual) begin
      next_code = reg_vcode;
    end else begin
      next_code = adj_code;
    end
    if (!en_bit) begin
      next_mv = 13'h0000;
    end else if (low_supply_mode) begin
      next_mv = `MFR_V3_BASE_MV + 13'(next_code) * `MFR_V3_STEP_MV;
    end else begin
      next_mv = `MFR_V5_BASE_MV + 13'(next_code) * `MFR_V5_STEP_MV;
    end
  end

  // regulator state and displayed voltage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_on <= 1'b0;
      power_down <= 1'b1;
      tx_rail_code <= 4'h0;
      tx_rail_mv <= 13'h0000;
      ad_rail_mv <= 13'h0000;
    end else begin
      reg_on <= en_bit;
      power_down <= !en_bit;
      tx_rail_code <= next_code;
      tx_rail_mv <= next_mv;
      // one shared voltage in 3.3 V mode, fixed otherwise
      if (!en_bit) begin
        ad_rail_mv <= 13'h0000;
      end else begin
        ad_rail_mv <= low_supply_mode ? next_mv : `MFR_AD_FIXED_MV;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_phs_acc;
    accept && next_src == mfr_pkg::SRC_PHASE;
  endsequence
  sequence s_amp_acc;
    accept && next_src == mfr_pkg::SRC_AMP;
  endsequence
  sequence s_phs_run;
    adc_src == mfr_pkg::SRC_PHASE && adc_ref_rel ##1 adc_ref_rel ##1 adc_ref_rel && cv_bus.busy;
  endsequence

  a_phase_route: assert property (@(posedge clk) disable iff (rst)
    s_phs_acc |=> s_phs_run)
    else $error("phase command not routed in relative mode");
  a_ref_phase: assert property (@(posedge clk) disable iff (rst)
    adc_ref_rel |-> adc_src == mfr_pkg::SRC_PHASE)
    else $error("relative reference outside phase measurement");
  a_amp_route: assert property (@(posedge clk) disable iff (rst)
    s_amp_acc |=> adc_src == mfr_pkg::SRC_AMP && !adc_ref_rel)
    else $error("amplitude command not routed");
  a_reg_manual: assert property (@(posedge clk) disable iff (rst)
    en_bit && reg_manual |=> tx_rail_code == $past(reg_vcode))
    else $error("manual code not applied");
  a_pd_mode: assert property (@(posedge clk) disable iff (rst)
    !en_bit |=> power_down && !reg_on && tx_rail_code == 4'h0)
    else $error("not powered down with enable low");
  a_ad_fixed: assert property (@(posedge clk) disable iff (rst)
    en_bit && !low_supply_mode |=> ad_rail_mv == `MFR_AD_FIXED_MV)
    else $error("analog rail not fixed in 5 V mode");
endmodule

// ===== tb/mfr_afe_model.sv
// analog front end stand-in: converter comparator and field comparator
`timescale 1ns/1ps
module mfr_afe_model (
  input wire logic clk,
  input wire logic [7:0] dac,
  input wire mfr_pkg::mfr_src_t src,
  input wire logic [7:0] phase_lvl,
  input wire logic [7:0] amp_lvl,
  input wire logic [7:0] sup_lvl,
  input wire logic [3:0] thr,
  input wire logic [3:0] field_lvl,
  output logic adc_cmp,
  output logic field_cmp
);
  logic [7:0] lvl; // voltage on the converter input, as a code
  // routed detector voltage; nothing routed reads as ground
  always_comb begin
    case (src)
      mfr_pkg::SRC_PHASE: lvl = phase_lvl;
      mfr_pkg::SRC_AMP: lvl = amp_lvl;
      mfr_pkg::SRC_SUP: lvl = sup_lvl;
      default: lvl = 8'h00;
    endcase
  end
  // comparators lag one cycle, like a real settling time; they run from
  // time zero, so both are settled long before reset is released
  always @(posedge clk) begin
    adc_cmp <= (lvl >= dac);
    field_cmp <= (field_lvl > thr);
  end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the measurement and supply control block
`timescale 1ns/1ps
`include "mfr_map.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_top;
  localparam int CC = 64; // short conversion, still 8 cycles a trial step
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, adc_cmp, field_cmp, fd_on, fd_irq, adc_ref_rel;
  logic reg_on, power_down, er;
  logic [7:0] adc_dac, phase_lvl = 8'h00, amp_lvl = 8'h00, sup_lvl = 8'h9C;
  logic [3:0] fd_thr_code, tx_rail_code, field_lvl = 4'h0;
  logic [12:0] tx_rail_mv, ad_rail_mv;
  mfr_pkg::mfr_src_t adc_src;
  int err_total = 0, n_compared = 0, irq_n = 0, cyc = 0;
  always #2 clk = ~clk;
  mfr_ctrl #(.CONV_CYC(CC)) i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_cmp(adc_cmp), .field_cmp(field_cmp), .adc_dac(adc_dac),
    .adc_ref_rel(adc_ref_rel), .adc_src(adc_src), .fd_thr_code(fd_thr_code), .fd_on(fd_on),
    .fd_irq(fd_irq), .reg_on(reg_on), .power_down(power_down), .tx_rail_code(tx_rail_code),
    .tx_rail_mv(tx_rail_mv), .ad_rail_mv(ad_rail_mv));
  mfr_afe_model i_afe (.clk(clk), .dac(adc_dac), .src(adc_src), .phase_lvl(phase_lvl),
    .amp_lvl(amp_lvl), .sup_lvl(sup_lvl), .thr(fd_thr_code), .field_lvl(field_lvl),
    .adc_cmp(adc_cmp), .field_cmp(field_cmp));
  // interrupt pulses counted in the background
  always @(posedge clk) begin
    if (fd_irq === 1'b1) begin
      irq_n++;
    end
  end
  // hang guard: far beyond the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end
  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1); // ends when pready is seen high; no timeout of its own
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // waits for the converter to let go of its input, bounded
  task automatic wait_idle(output int n);
    n = 0;
    while (adc_src !== mfr_pkg::SRC_IDLE && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic conv(input logic [2:0] c, input mfr_pkg::mfr_src_t s, input logic rel);
    int n;
    apb(1'b1, `MFR_A_CMD, {29'h0, c});
    settle(1);
    `CHK("src", s, adc_src)
    `CHK("ref", rel, adc_ref_rel)
    wait_idle(n);
    `CHK("conv time", 1'b1, n >= CC && n <= CC + 3)
  endtask
  task automatic t_reset;
    settle(1);
    `CHK("pd", 1'b1, power_down)
    `CHK("reg_on", 1'b0, reg_on)
    apb(1'b0, `MFR_A_IOCFG, 32'h0);
    `CHK("iocfg", 32'h0, rd)
    apb(1'b0, `MFR_A_REGV, 32'h0);
    `CHK("regv", 32'h0, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, `MFR_A_CMD, 32'h1); // must be dropped while powered down
    settle(1);
    `CHK("pd src", mfr_pkg::SRC_IDLE, adc_src)
    $display("test reset done");
  endtask
  task automatic t_meas;
    int n;
    apb(1'b1, `MFR_A_OPCTL, 32'h1);
    amp_lvl <= 8'hA5;
    phase_lvl <= 8'hE0;
    conv(3'h1, mfr_pkg::SRC_AMP, 1'b0);
    apb(1'b0, `MFR_A_ADC, 32'h0);
    `CHK("amp", 32'hA5, rd)
    conv(3'h3, mfr_pkg::SRC_PHASE, 1'b1); // phase outranks amplitude
    apb(1'b0, `MFR_A_ADC, 32'h0);
    `CHK("phase", 32'hE0, rd)
    phase_lvl <= 8'h30;
    conv(3'h2, mfr_pkg::SRC_PHASE, 1'b1);
    apb(1'b0, `MFR_A_ADC, 32'h0);
    `CHK("phase far", 32'h30, rd)
    apb(1'b1, `MFR_A_CMD, 32'h1);
    apb(1'b1, `MFR_A_CMD, 32'h2); // second request while busy is dropped
    `CHK("busy src", mfr_pkg::SRC_AMP, adc_src)
    `CHK("busy ref", 1'b0, adc_ref_rel)
    apb(1'b0, `MFR_A_AUX, 32'h0);
    `CHK("aux busy", 1'b1, rd[1])
    apb(1'b0, `MFR_A_ADC, 32'h0);
    `CHK("held", 32'h30, rd)
    wait_idle(n);
    apb(1'b0, `MFR_A_ADC, 32'h0);
    `CHK("amp again", 32'hA5, rd)
    $display("test meas done");
  endtask
  task automatic t_field;
    apb(1'b1, `MFR_A_FDTHR, 32'h2638); // activation above deactivation
    apb(1'b1, `MFR_A_OPCTL, 32'h5);
    field_lvl <= 4'h9;
    settle(8);
    `CHK("fd on", 1'b1, fd_on)
    `CHK("thr deact", 4'h3, fd_thr_code)
    `CHK("irq on", 1, irq_n)
    apb(1'b0, `MFR_A_AUX, 32'h0);
    `CHK("aux fd", 1'b1, rd[0])
    field_lvl <= 4'h5;
    settle(8);
    `CHK("hyst", 1'b1, fd_on)
    field_lvl <= 4'h2;
    settle(8);
    `CHK("fd off", 1'b0, fd_on)
    `CHK("thr act", 4'h8, fd_thr_code)
    `CHK("irq off", 2, irq_n)
    apb(1'b1, `MFR_A_OPCTL, 32'h3);
    field_lvl <= 4'h7;
    settle(8);
    `CHK("ca on", 1'b1, fd_on)
    `CHK("ca thr", 4'h2, fd_thr_code)
    `CHK("ca no irq", 2, irq_n)
    apb(1'b1, `MFR_A_OPCTL, 32'h1);
    settle(8);
    `CHK("fd off sel", 1'b0, fd_on)
    $display("test field done");
  endtask
  task automatic t_reg;
    conv(3'h4, mfr_pkg::SRC_SUP, 1'b0);
    settle(2);
    apb(1'b0, `MFR_A_REGD, 32'h0);
    `CHK("adj code", 32'h9, rd)
    `CHK("adj mv", 13'h1248, tx_rail_mv)
    `CHK("ad 5v", 13'h0D48, ad_rail_mv)
    apb(1'b1, `MFR_A_IOCFG, 32'h1); // low supply set by host
    apb(1'b1, `MFR_A_REGV, 32'h15);
    settle(2);
    `CHK("mv 3v", 13'h0B54, tx_rail_mv)
    `CHK("ad 3v", 13'h0B54, ad_rail_mv)
    apb(1'b0, `MFR_A_REGD, 32'h0);
    `CHK("man code", 32'h5, rd)
    apb(1'b1, `MFR_A_IOCFG, 32'h0);
    apb(1'b1, `MFR_A_REGV, 32'h1F);
    settle(2);
    `CHK("mv 5v top", 13'h1518, tx_rail_mv)
    `CHK("reg on", 1'b1, reg_on)
    apb(1'b1, `MFR_A_OPCTL, 32'h0);
    settle(2);
    `CHK("pd again", 1'b1, power_down)
    `CHK("code off", 4'h0, tx_rail_code)
    $display("test reg done");
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_meas;
    t_field;
    t_reg;
    test_done;
  end
endmodule
